//--- hw/fsps_pkg.sv
// Package of constants and types for the flash self-program section logic
package fsps_pkg;
    // Word address width of the program store (32K words)
    localparam int unsigned ADDR_W          = 15;
    // Page size in words, log2
    localparam int unsigned PAGE_LOG2       = 7;
    // First word of the halting region; everything above is halting
    localparam logic [14:0] HALT_BASE       = 15'h7000;
    // Boot loader start for each boot size setting (00 largest)
    localparam logic [14:0] BOOT_BASE_0     = 15'h7000;
    localparam logic [14:0] BOOT_BASE_1     = 15'h7800;
    localparam logic [14:0] BOOT_BASE_2     = 15'h7c00;
    localparam logic [14:0] BOOT_BASE_3     = 15'h7e00;
    // Operation time, microseconds, and its cycle count at 40 MHz
    localparam int unsigned PROG_TIME_US    = 4000;
    localparam int unsigned CLK_MHZ         = 40;
    localparam int unsigned PROG_CYCLES     = PROG_TIME_US * CLK_MHZ;
    // Register offsets on the plain register port
    localparam logic [3:0]  REG_CTRL_STAT   = 4'h0;
    localparam logic [3:0]  REG_LOCK        = 4'h1;
    localparam logic [3:0]  REG_TARGET_LO   = 4'h2;
    localparam logic [3:0]  REG_TARGET_HI   = 4'h3;
    // Field positions in the control and status register
    localparam int unsigned BIT_BUSY        = 6;
    localparam int unsigned BIT_RBUSY_CLR   = 4;
    localparam int unsigned BIT_ACTIVE      = 0;
    // Lock register field positions and reset (unprogrammed) value
    localparam int unsigned LOCK_APP_LSB    = 0;
    localparam int unsigned LOCK_BOOT_LSB   = 2;
    localparam logic [3:0]  LOCK_RESET      = 4'hf;
    // Operation kinds
    typedef enum logic [1:0] {
        FSPS_OP_ERASE = 2'h1,
        FSPS_OP_WRITE = 2'h2
    } fsps_op_t;
    // Sequencer states, one-hot
    typedef enum logic [2:0] {
        FSPS_IDLE  = 3'b001,
        FSPS_RUN   = 3'b010,
        FSPS_DONE  = 3'b100
    } fsps_state_t;
endpackage

//--- hw/fsps_req_if.sv
// Interface carrying a checked program-store request inside fsps_top
`timescale 1ns/1ps
interface fsps_req_if;
    logic        start;
    logic        op_write;
    logic [14:0] addr;
    logic        in_halt;
    logic        done;
    modport ctl (output start, output op_write, output addr,
                 output in_halt, input done);
    modport seq (input start, input op_write, input addr,
                 input in_halt, output done);
endinterface

//--- hw/fsps_region.sv
// Section and protection decode for a program-store request
`timescale 1ns/1ps
module fsps_region (
    input  wire logic [14:0] pc_addr,
    input  wire logic [14:0] tgt_addr,
    input  wire logic [1:0]  boot_size_fuses,
    input  wire logic [3:0]  lock_bits,
    output logic             pc_in_boot,
    output logic             tgt_in_boot,
    output logic             tgt_in_halt,
    output logic             write_ok
);
    logic [14:0] boot_base;

    // Boot base picked by fuses; every choice lies in halting region
    always_comb begin
        case (boot_size_fuses)
            2'h0:    boot_base = fsps_pkg::BOOT_BASE_0;
            2'h1:    boot_base = fsps_pkg::BOOT_BASE_1;
            2'h2:    boot_base = fsps_pkg::BOOT_BASE_2;
            default: boot_base = fsps_pkg::BOOT_BASE_3;
        endcase
    end

    // Boot boundary from boot size fuses; halting boundary fixed at HALT_BASE
    assign pc_in_boot  = pc_addr >= boot_base;
    assign tgt_in_boot = tgt_addr >= boot_base;
    assign tgt_in_halt = tgt_addr >= fsps_pkg::HALT_BASE;

    // Mode 2/3 forbid writes: low bit programmed (0)
    always_comb begin
        if (tgt_in_boot) begin
            write_ok = lock_bits[fsps_pkg::LOCK_BOOT_LSB];
        end else begin
            write_ok = lock_bits[fsps_pkg::LOCK_APP_LSB];
        end
    end
endmodule

//--- hw/fsps_top.sv
// Flash self-program section control: start check, stall, read block
`timescale 1ns/1ps
// Summary of operation
// - Program store starts only from boot section
// - Boot section may target any flash address
// - Boot size fuses set section boundary
// - Application protection from first lock pair
// - Boot section protection from second lock pair
// - Concurrent region programming keeps CPU running
// - Halting region programming stalls CPU throughout
// - Concurrent region unreadable during any programming
// - Boot section always inside halting region
// - Busy flag reads one while blocked
// - Busy flag stays until software clears
// - Target address latched at start
// - Lock bits restored only by chip erase or reset
module fsps_top #(
    parameter int unsigned PROG_CYCLES = fsps_pkg::PROG_CYCLES
) (
    input  wire logic        core_clk,
    input  wire logic        rst_n,
    input  wire logic        program_store_instr,
    input  wire logic        op_write,
    input  wire logic [14:0] pc_addr,
    input  wire logic [14:0] ptr_addr,
    input  wire logic [1:0]  boot_size_fuses,
    input  wire logic        chip_erase,
    input  wire logic [3:0]  reg_addr,
    input  wire logic [7:0]  reg_wdata,
    input  wire logic        reg_wr,
    input  wire logic        reg_rd,
    output logic [7:0]       reg_rdata,
    output logic             cpu_stall,
    output logic             read_block,
    output logic             flash_busy,
    output logic             flash_op_start,
    output logic             flash_op_write,
    output logic [14:0]      flash_op_addr
);
    // Timer needs at least one run cycle before its done cycle
    if (PROG_CYCLES < 2) begin : g_bad_cycles
        $error("PROG_CYCLES must be at least 2");
    end

    fsps_pkg::fsps_state_t state_q;
    logic [31:0] cnt_q;
    logic [3:0]  lock_q;
    logic        region_busy_flag_q;
    logic        halt_op_q;
    logic        pc_in_boot;
    logic        tgt_in_boot;
    logic        tgt_in_halt;
    logic        write_ok;
    logic        accept;
    fsps_req_if  req ();

    fsps_region u_region (
        .pc_addr         (pc_addr),
        .tgt_addr        (ptr_addr),
        .boot_size_fuses (boot_size_fuses),
        .lock_bits       (lock_q),
        .pc_in_boot      (pc_in_boot),
        .tgt_in_boot     (tgt_in_boot),
        .tgt_in_halt     (tgt_in_halt),
        .write_ok        (write_ok)
    );

    // Accept: from boot code, any target, lock permitting
    assign accept = program_store_instr && pc_in_boot && write_ok
                    && (state_q == fsps_pkg::FSPS_IDLE);
    assign req.start    = accept;
    assign req.op_write = op_write;
    assign req.addr     = ptr_addr;
    assign req.in_halt  = tgt_in_halt;
    assign req.done     = (state_q == fsps_pkg::FSPS_RUN)
                          && (cnt_q == 32'h0000_0001);

    // Sequencer; a second store while running is ignored
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            state_q <= fsps_pkg::FSPS_IDLE;
        end else begin
            case (state_q)
                fsps_pkg::FSPS_IDLE: begin
                    if (req.start) begin
                        state_q <= fsps_pkg::FSPS_RUN;
                    end
                end
                fsps_pkg::FSPS_RUN: begin
                    if (req.done) begin
                        state_q <= fsps_pkg::FSPS_DONE;
                    end
                end
                fsps_pkg::FSPS_DONE: state_q <= fsps_pkg::FSPS_IDLE;
                default:             state_q <= fsps_pkg::FSPS_IDLE;
            endcase
        end
    end

    // Operation timer
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            cnt_q <= 32'h0000_0000;
        end else if (req.start) begin
            cnt_q <= PROG_CYCLES;
        end else if (cnt_q != 32'h0000_0000) begin
            cnt_q <= cnt_q - 32'h0000_0001;
        end
    end

    // Latch target so pointer is free during the operation
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            flash_op_addr  <= 15'h0000;
            flash_op_write <= 1'b0;
            halt_op_q      <= 1'b0;
        end else if (req.start) begin
            flash_op_addr  <= req.addr;
            flash_op_write <= req.op_write;
            halt_op_q      <= req.in_halt;
        end
    end

    // One-cycle start strobe to the array
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            flash_op_start <= 1'b0;
        end else begin
            flash_op_start <= req.start;
        end
    end

    // Stall only for halting-region targets
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            cpu_stall <= 1'b0;
        end else if (req.start) begin
            cpu_stall <= req.in_halt;
        end else if (req.done) begin
            cpu_stall <= 1'b0;
        end
    end

    // Overall busy, for status
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            flash_busy <= 1'b0;
        end else if (req.start) begin
            flash_busy <= 1'b1;
        end else if (req.done) begin
            flash_busy <= 1'b0;
        end
    end

    // Busy flag: set on start wins over clear; clear refused mid-op
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            region_busy_flag_q <= 1'b0;
        end else if (req.start) begin
            region_busy_flag_q <= 1'b1;
        end else if (reg_wr && reg_addr == fsps_pkg::REG_CTRL_STAT
                     && reg_wdata[fsps_pkg::BIT_RBUSY_CLR]
                     && state_q == fsps_pkg::FSPS_IDLE) begin
            region_busy_flag_q <= 1'b0;
        end
    end

    // Concurrent region blocked while flag set
    assign read_block = region_busy_flag_q;

    // Lock bits: program only (1->0); chip erase restores
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            lock_q <= fsps_pkg::LOCK_RESET;
        end else if (chip_erase) begin
            lock_q <= fsps_pkg::LOCK_RESET;
        end else if (reg_wr && reg_addr == fsps_pkg::REG_LOCK) begin
            lock_q <= lock_q & reg_wdata[3:0];
        end
    end

    // Register read, data valid the cycle after the strobe
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            reg_rdata <= 8'h00;
        end else if (reg_rd) begin
            case (reg_addr)
                fsps_pkg::REG_CTRL_STAT: reg_rdata <=
                    {1'b0, region_busy_flag_q, 5'h00, flash_busy};
                fsps_pkg::REG_LOCK:      reg_rdata <= {4'h0, lock_q};
                fsps_pkg::REG_TARGET_LO: reg_rdata <= flash_op_addr[7:0];
                fsps_pkg::REG_TARGET_HI: reg_rdata <=
                    {1'b0, flash_op_addr[14:8]};
                default:                 reg_rdata <= 8'h00;
            endcase
        end else begin
            reg_rdata <= 8'h00;
        end
    end

    // Assertions
    property p_app_ignored;
        @(posedge core_clk) disable iff (!rst_n)
        (program_store_instr && !pc_in_boot) |=> !flash_op_start;
    endproperty
    a_app_ignored: assert property (p_app_ignored)
        else $error("store from application section started op");

    property p_stall_halt;
        @(posedge core_clk) disable iff (!rst_n)
        (accept && tgt_in_halt) |=> cpu_stall [*8];
    endproperty
    a_stall_halt: assert property (p_stall_halt)
        else $error("halting region op did not stall cpu");

    property p_no_stall_rww;
        @(posedge core_clk) disable iff (!rst_n)
        (accept && !tgt_in_halt) |=> !cpu_stall;
    endproperty
    a_no_stall_rww: assert property (p_no_stall_rww)
        else $error("concurrent region op stalled cpu");

    property p_busy_set;
        @(posedge core_clk) disable iff (!rst_n)
        accept |=> region_busy_flag_q && read_block;
    endproperty
    a_busy_set: assert property (p_busy_set)
        else $error("busy flag not set at start");

    property p_busy_holds;
        @(posedge core_clk) disable iff (!rst_n)
        (region_busy_flag_q && !(reg_wr && reg_addr ==
         fsps_pkg::REG_CTRL_STAT)) |=> region_busy_flag_q;
    endproperty
    a_busy_holds: assert property (p_busy_holds)
        else $error("busy flag dropped without software clear");

    property p_block_in_op;
        @(posedge core_clk) disable iff (!rst_n)
        flash_busy |-> read_block;
    endproperty
    a_block_in_op: assert property (p_block_in_op)
        else $error("concurrent region readable during op");

    property p_latch;
        @(posedge core_clk) disable iff (!rst_n)
        accept |=> flash_op_addr == $past(ptr_addr) && flash_op_start;
    endproperty
    a_latch: assert property (p_latch)
        else $error("target address not latched");

    property p_lock_sticky;
        @(posedge core_clk) disable iff (!rst_n)
        !chip_erase |=> (lock_q & ~$past(lock_q)) == 4'h0;
    endproperty
    a_lock_sticky: assert property (p_lock_sticky)
        else $error("lock bit returned to unprogrammed");

    property p_status_read;
        @(posedge core_clk) disable iff (!rst_n)
        (reg_rd && reg_addr == fsps_pkg::REG_CTRL_STAT)
        |=> reg_rdata[fsps_pkg::BIT_BUSY] == $past(region_busy_flag_q);
    endproperty
    a_status_read: assert property (p_status_read)
        else $error("status read busy bit mismatch");

    // Locked sections must refuse a store even from boot code
    property p_app_locked;
        @(posedge core_clk) disable iff (!rst_n)
        (program_store_instr && !tgt_in_boot
         && !lock_q[fsps_pkg::LOCK_APP_LSB]) |=> !flash_op_start;
    endproperty
    a_app_locked: assert property (p_app_locked)
        else $error("write to locked application section started");

    property p_boot_locked;
        @(posedge core_clk) disable iff (!rst_n)
        (program_store_instr && tgt_in_boot
         && !lock_q[fsps_pkg::LOCK_BOOT_LSB]) |=> !flash_op_start;
    endproperty
    a_boot_locked: assert property (p_boot_locked)
        else $error("write to locked boot section started");

    // Clear strobes are refused until the sequencer is back in idle
    property p_clear_refused;
        @(posedge core_clk) disable iff (!rst_n)
        (region_busy_flag_q && state_q != fsps_pkg::FSPS_IDLE)
        |=> region_busy_flag_q;
    endproperty
    a_clear_refused: assert property (p_clear_refused)
        else $error("busy flag cleared while operation ran");

    property p_stall_ends;
        @(posedge core_clk) disable iff (!rst_n)
        !flash_busy |-> !cpu_stall;
    endproperty
    a_stall_ends: assert property (p_stall_ends)
        else $error("cpu stalled with no operation running");

    c_locked:  cover property (@(posedge core_clk)
        program_store_instr && pc_in_boot && !write_ok);
    c_rww_op:  cover property (@(posedge core_clk) accept && !tgt_in_halt);
    c_halt_op: cover property (@(posedge core_clk) accept && tgt_in_halt);
    c_clear:   cover property (@(posedge core_clk)
        $fell(region_busy_flag_q));
endmodule

//--- verification/fsps_core_model.sv
// Behavioural processor core issuing program-store instructions
`timescale 1ns/1ps
module fsps_core_model (
    input  wire logic        core_clk,
    input  wire logic        rst_n,
    input  wire logic        cpu_stall,
    input  wire logic        req,
    input  wire logic        req_write,
    input  wire logic [14:0] req_pc,
    input  wire logic [14:0] req_ptr,
    output logic             program_store_instr,
    output logic             op_write,
    output logic [14:0]      pc_addr,
    output logic [14:0]      ptr_addr
);
    // One store pulse per request; a halted core executes nothing
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            program_store_instr <= 1'b0;
            op_write            <= 1'b0;
            pc_addr             <= 15'h0000;
            ptr_addr            <= 15'h0000;
        end else begin
            program_store_instr <= req && !cpu_stall;
            // PC follows the request, from any region, no interrupts
            pc_addr <= req_pc;
            if (req && !cpu_stall) begin
                ptr_addr <= req_ptr;
                op_write <= req_write;
            end else begin
                // Pointer reused for other work, so it keeps moving
                ptr_addr <= ~ptr_addr;
                op_write <= ~op_write;
            end
        end
    end
endmodule

//--- verification/flash_self_program_sections_bench.sv
// Self-checking bench for the flash self-program section logic
`timescale 1ns/1ps
`define CHK(a, b) begin checks++; if ((a) !== (b)) begin fail_count++; \
    $display("wrong value at %0t: got %h expected %h", $time, a, b); end end
module flash_self_program_sections_bench;
    localparam int unsigned P = 20;
    logic        core_clk = 1'b0;
    logic        rst_n = 1'b0;
    logic        req = 1'b0;
    logic        req_write = 1'b0;
    logic [14:0] req_pc = 15'h0000;
    logic [14:0] req_ptr = 15'h0000;
    logic        program_store_instr;
    logic        op_write;
    logic [14:0] pc_addr;
    logic [14:0] ptr_addr;
    logic [1:0]  boot_size_fuses = 2'h0;
    logic        chip_erase = 1'b0;
    logic [3:0]  reg_addr = 4'h0;
    logic [7:0]  reg_wdata = 8'h00;
    logic        reg_wr = 1'b0;
    logic        reg_rd = 1'b0;
    logic [7:0]  reg_rdata;
    logic        cpu_stall;
    logic        read_block;
    logic        flash_busy;
    logic        flash_op_start;
    logic        flash_op_write;
    logic [14:0] flash_op_addr;
    logic [14:0] bases [4];
    int          fail_count = 0;
    int          checks = 0;
    int          st;

    // Core clock, 25 ns period
    always #12.5 core_clk = ~core_clk;

    fsps_core_model fsps_core_model_i (.core_clk(core_clk), .rst_n(rst_n),
        .cpu_stall(cpu_stall), .req(req), .req_write(req_write),
        .req_pc(req_pc), .req_ptr(req_ptr),
        .program_store_instr(program_store_instr), .op_write(op_write),
        .pc_addr(pc_addr), .ptr_addr(ptr_addr));

    fsps_top #(.PROG_CYCLES(P)) fsps_top_i (.core_clk(core_clk),
        .rst_n(rst_n), .program_store_instr(program_store_instr),
        .op_write(op_write), .pc_addr(pc_addr), .ptr_addr(ptr_addr),
        .boot_size_fuses(boot_size_fuses), .chip_erase(chip_erase),
        .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
        .reg_rd(reg_rd), .reg_rdata(reg_rdata), .cpu_stall(cpu_stall),
        .read_block(read_block), .flash_busy(flash_busy),
        .flash_op_start(flash_op_start), .flash_op_write(flash_op_write),
        .flash_op_addr(flash_op_addr));

    task automatic wr(input logic [3:0] a, input logic [7:0] d);
        @(posedge core_clk);
        reg_addr  <= a;
        reg_wdata <= d;
        reg_wr    <= 1'b1;
        @(posedge core_clk);
        reg_wr    <= 1'b0;
    endtask

    // Read data stands only in the cycle after the strobe
    task automatic rd(input logic [3:0] a, input logic [7:0] e);
        @(posedge core_clk);
        reg_addr <= a;
        reg_rd   <= 1'b1;
        @(posedge core_clk);
        reg_rd   <= 1'b0;
        #1;
        `CHK(reg_rdata, e)
    endtask

    // Issue a store and see whether it starts, with latched kind and target
    task automatic store(input logic [14:0] pc, input logic [14:0] ptr,
                         input logic w, input logic acc);
        int n;
        n = 0;
        @(posedge core_clk);
        req       <= 1'b1;
        req_pc    <= pc;
        req_ptr   <= ptr;
        req_write <= w;
        @(posedge core_clk);
        req <= 1'b0;
        while (flash_op_start !== 1'b1 && n < 4) begin
            @(posedge core_clk);
            #1;
            n++;
        end
        `CHK(flash_op_start, acc)
        if (acc) begin
            `CHK(flash_op_addr, ptr)
            `CHK(flash_op_write, w)
        end
    endtask

    // Wait out an operation, counting stalled cycles; bounded wait
    task automatic finish_op(output int s);
        int n;
        n = 0;
        s = 0;
        while (flash_busy === 1'b1 && n < 200) begin
            if (cpu_stall === 1'b1)
                s++;
            @(posedge core_clk);
            #1;
            n++;
        end
        // A wait that runs out leaves busy high and counts as a mismatch
        `CHK(flash_busy, 1'b0)
        repeat (2) @(posedge core_clk);
    endtask

    task automatic end_sim;
        $display("checks %0d fail_count %0d", checks, fail_count);
        if (fail_count == 0 && checks > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask

    // Main sequence
    initial begin
        bases = '{fsps_pkg::BOOT_BASE_0, fsps_pkg::BOOT_BASE_1,
                  fsps_pkg::BOOT_BASE_2, fsps_pkg::BOOT_BASE_3};
        repeat (6) @(posedge core_clk);
        rst_n <= 1'b1;
        rd(fsps_pkg::REG_CTRL_STAT, 8'h00);
        rd(fsps_pkg::REG_LOCK, 8'h0f);
        rd(4'h5, 8'h00);
        store(15'h0100, 15'h0200, 1'b1, 1'b0);
        // Boot code writes the concurrent region; second store refused
        store(15'h7000, 15'h0100, 1'b1, 1'b1);
        `CHK(cpu_stall, 1'b0)
        `CHK(read_block, 1'b1)
        rd(fsps_pkg::REG_CTRL_STAT, 8'h41);
        store(15'h7000, 15'h0300, 1'b0, 1'b0);
        // Clear while the operation runs must be refused
        wr(fsps_pkg::REG_CTRL_STAT, 8'h10);
        rd(fsps_pkg::REG_TARGET_LO, 8'h00);
        rd(fsps_pkg::REG_TARGET_HI, 8'h01);
        `CHK(read_block, 1'b1)
        finish_op(st);
        `CHK(st, 0)
        `CHK(read_block, 1'b1)
        rd(fsps_pkg::REG_CTRL_STAT, 8'h40);
        wr(fsps_pkg::REG_CTRL_STAT, 8'h10);
        @(posedge core_clk);
        #1;
        `CHK(read_block, 1'b0)
        // Section boundary per fuse setting; boot section always halts
        for (int i = 0; i < 4; i++) begin
            boot_size_fuses <= 2'(i);
            store(bases[i] - 15'h0001, 15'h0080, 1'b1, 1'b0);
            store(bases[i], bases[i], 1'b0, 1'b1);
            `CHK(cpu_stall, 1'b1)
            finish_op(st);
            `CHK(st >= P - 1 && st <= P, 1'b1)
        end
        boot_size_fuses <= 2'h0;
        // Lock pairs guard their own sections; writing ones does not restore, chip erase does
        wr(fsps_pkg::REG_LOCK, 8'h0e);
        rd(fsps_pkg::REG_LOCK, 8'h0e);
        store(15'h7000, 15'h0100, 1'b1, 1'b0);
        store(15'h7000, 15'h7e00, 1'b1, 1'b1);
        finish_op(st);
        wr(fsps_pkg::REG_LOCK, 8'h0b);
        store(15'h7000, 15'h7e00, 1'b1, 1'b0);
        wr(fsps_pkg::REG_LOCK, 8'h0f);
        rd(fsps_pkg::REG_LOCK, 8'h0a);
        @(posedge core_clk);
        chip_erase <= 1'b1;
        @(posedge core_clk);
        chip_erase <= 1'b0;
        rd(fsps_pkg::REG_LOCK, 8'h0f);
        end_sim();
    end

    // Watchdog, well beyond the expected run length
    initial begin
        #(25 * 6000);
        fail_count++;
        end_sim();
    end
endmodule
